// [include/lnbctl_pkg.sv]
// lnbctl_pkg: constants for the dual lnb control register bank
// assumes a byte-wide write port from a serial protocol engine
`default_nettype none
package lnbctl_pkg;
   // ****************************************
   // register select field and bit positions
   // ****************************************
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 6;
   localparam logic [1:0] SEL_CH1_VOLT = 2'h0;
   localparam logic [1:0] SEL_CH2_VOLT = 2'h1;
   localparam logic [1:0] SEL_CH1_TONE = 2'h2;
   localparam logic [1:0] SEL_CH2_TONE = 2'h3;
   localparam int VOLT_STEP_LSB = 0;
   localparam int VOLT_STEP_MSB = 2;
   localparam int VOLT_RANGE_BIT = 3;
   localparam int OC_TIMER_BIT = 4;
   localparam int OUTPUT_ON_BIT = 5;
   localparam int TONE_SRC_BIT = 0;
   localparam int TONE_PASS_BIT = 1;
   localparam int CABLE_TEST_BIT = 2;
   localparam int NUM_CH = 2;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [5:0] VOLT_RESET = 6'h00;
   localparam logic [2:0] TONE_RESET = 3'h0;
   localparam logic [15:0] TARGET_RESET = 16'h0000;
   localparam logic FLAG_RESET = 1'h0;
   localparam logic [1:0] SYNC_RESET = 2'h0;
   // ****************************************
   // output level table, millivolts
   // ****************************************
   localparam int LOW_BASE_MV = 12709;
   localparam int HIGH_BASE_MV = 18042;
   localparam int STEP_MV = 333;
   localparam int TOP_MV = 20375;
   // millivolts in hex: 12709 .. 15042, then 18042 .. 20375
   localparam logic [15:0] LEVEL_MV [16] = '{
      16'h31a5, 16'h32f2, 16'h343f, 16'h358d,
      16'h36da, 16'h3827, 16'h3975, 16'h3ac2,
      16'h467a, 16'h47c7, 16'h4915, 16'h4a62,
      16'h4baf, 16'h4cfd, 16'h4e4a, 16'h4f97};
   // 21000, 19950 and 22800 mV
   localparam logic [15:0] CABLE_OPEN_MV = 16'h5208;
   localparam logic [15:0] CABLE_CLOSED_MV = 16'h4dee;
   localparam logic [15:0] BOOST_TEST_MV = 16'h5910;
endpackage
`default_nettype wire

// [include/lnbctl_ch_if.sv]
// lnbctl_ch_if: per-channel control between top and channel module
// assumes one instance per channel, same clock domain
`timescale 1ns/1ps
`default_nettype none
interface lnbctl_ch_if;
   logic [5:0] volt_field;
   logic [2:0] tone_field;
   modport ctrl (output volt_field, output tone_field);
   modport chan (input volt_field, input tone_field);
endinterface
`default_nettype wire

// [hw/lnbctl_chan.sv]
// lnbctl_chan: decodes one channel's control fields into analog controls
// assumes the comparator levels come from same-domain sampling logic
`timescale 1ns/1ps
`default_nettype none
module lnbctl_chan (
   input wire logic core_clk,
   input wire logic srst,
   lnbctl_ch_if.chan cif,
   input wire logic cmp_above_set,
   input wire logic cmp_below_clr,
   output logic [15:0] target_mv,
   output logic output_on,
   output logic overcurrent_timer_enable,
   output logic tone_source_select,
   output logic tone_pass,
   output logic cable_test_on,
   output logic regulator_on,
   output logic test_source_on,
   output logic boost_raise,
   output logic cable_missing_flag
);
   logic [3:0] code;
   logic next_cable_missing_flag;
   logic [15:0] next_target;
   always_comb begin
      code = cif.volt_field[3:0];
      next_target = lnbctl_pkg::LEVEL_MV[code];
      next_cable_missing_flag = cable_missing_flag;
      // flag means nothing outside the test, so it is held low then
      if (!cif.tone_field[lnbctl_pkg::CABLE_TEST_BIT]) begin
         next_cable_missing_flag = 1'b0;
      end else if (cmp_above_set) begin
         next_cable_missing_flag = 1'b1;
      end else if (cmp_below_clr) begin
         next_cable_missing_flag = 1'b0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         cable_missing_flag <= lnbctl_pkg::FLAG_RESET;
         target_mv <= lnbctl_pkg::TARGET_RESET;
      end else begin
         cable_missing_flag <= next_cable_missing_flag;
         target_mv <= next_target;
      end
   end
   // timer stays armed whatever software wrote
   assign overcurrent_timer_enable = 1'b1;
   assign output_on = cif.volt_field[lnbctl_pkg::OUTPUT_ON_BIT];
   assign tone_source_select = cif.tone_field[lnbctl_pkg::TONE_SRC_BIT];
   assign tone_pass = cif.tone_field[lnbctl_pkg::TONE_PASS_BIT];
   assign cable_test_on = cif.tone_field[lnbctl_pkg::CABLE_TEST_BIT];
   assign regulator_on = output_on & ~cable_test_on;
   assign test_source_on = cable_test_on;
   assign boost_raise = cable_test_on;
   cable_set_a: assert property (
      @(posedge core_clk) disable iff (srst)
      cable_test_on && cmp_above_set |=> cable_missing_flag)
      else $error("cable flag not set");
   cable_clr_a: assert property (
      @(posedge core_clk) disable iff (srst)
      cable_test_on && !cmp_above_set && cmp_below_clr
      |=> !cable_missing_flag)
      else $error("cable flag not cleared");
   level_map_a: assert property (
      @(posedge core_clk) disable iff (srst)
      $stable(code) |=> target_mv == lnbctl_pkg::LEVEL_MV[$past(code)])
      else $error("level mismatch");
   reg_off_a: assert property (
      @(posedge core_clk) disable iff (srst)
      cable_test_on |-> !regulator_on && test_source_on && boost_raise)
      else $error("regulator on in test");
endmodule
`default_nettype wire

// [hw/lnbctl_top.sv]
// lnbctl_top: write-only control bank for two lnb supply channels
// assumes wr_strobe is a one-cycle pulse from the serial engine, same clock
`timescale 1ns/1ps
`default_nettype none
module lnbctl_top (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic wr_strobe,
   input wire logic [7:0] wr_data,
   input wire logic [1:0] cmp_above_set_pin,
   input wire logic [1:0] cmp_below_clr_pin,
   output logic [31:0] target_mv,
   output logic [1:0] output_on,
   output logic [1:0] overcurrent_timer_enable,
   output logic [1:0] tone_source_select,
   output logic [1:0] tone_pass,
   output logic [1:0] cable_test_on,
   output logic [1:0] regulator_on,
   output logic [1:0] test_source_on,
   output logic [1:0] boost_raise,
   output logic [1:0] cable_missing_flag
);
   // ****************************************
   // register state
   // ****************************************
   logic [5:0] volt_reg [2];
   logic [2:0] tone_reg [2];
   logic [5:0] next_volt [2];
   logic [2:0] next_tone [2];
   logic [1:0] sel;
   logic [1:0] above_s1, above_s2, below_s1, below_s2;
   logic [1:0] next_above_s1, next_above_s2, next_below_s1, next_below_s2;
   always_comb begin
      sel = wr_data[lnbctl_pkg::SEL_HI:lnbctl_pkg::SEL_LO];
      next_volt = volt_reg;
      next_tone = tone_reg;
      // one byte per write, so each strobe hits exactly one register
      if (wr_strobe) begin
         case (sel)
            lnbctl_pkg::SEL_CH1_VOLT: next_volt[0] = wr_data[5:0];
            lnbctl_pkg::SEL_CH2_VOLT: next_volt[1] = wr_data[5:0];
            lnbctl_pkg::SEL_CH1_TONE: next_tone[0] = wr_data[2:0];
            lnbctl_pkg::SEL_CH2_TONE: next_tone[1] = wr_data[2:0];
            default: next_tone = tone_reg;
         endcase
      end
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         volt_reg[0] <= lnbctl_pkg::VOLT_RESET;
         volt_reg[1] <= lnbctl_pkg::VOLT_RESET;
         tone_reg[0] <= lnbctl_pkg::TONE_RESET;
         tone_reg[1] <= lnbctl_pkg::TONE_RESET;
      end else begin
         volt_reg <= next_volt;
         tone_reg <= next_tone;
      end
   end
   // ****************************************
   // comparator synchronisers
   // ****************************************
   // analog comparators are asynchronous to the bus clock, so two flops
   // come first; costs two cycles of flag latency
   always_comb begin
      next_above_s1 = cmp_above_set_pin;
      next_above_s2 = above_s1;
      next_below_s1 = cmp_below_clr_pin;
      next_below_s2 = below_s1;
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         above_s1 <= lnbctl_pkg::SYNC_RESET;
         above_s2 <= lnbctl_pkg::SYNC_RESET;
         below_s1 <= lnbctl_pkg::SYNC_RESET;
         below_s2 <= lnbctl_pkg::SYNC_RESET;
      end else begin
         above_s1 <= next_above_s1;
         above_s2 <= next_above_s2;
         below_s1 <= next_below_s1;
         below_s2 <= next_below_s2;
      end
   end
   // ****************************************
   // per-channel decode
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < lnbctl_pkg::NUM_CH; g++) begin : ch
         lnbctl_ch_if cif ();
         assign cif.volt_field = volt_reg[g];
         // master must also set enable and voltage for a valid test
         assign cif.tone_field = tone_reg[g];
         lnbctl_chan u_chan (
            .core_clk(core_clk),
            .srst(srst),
            .cif(cif),
            .cmp_above_set(above_s2[g]),
            .cmp_below_clr(below_s2[g]),
            .target_mv(target_mv[16*g+:16]),
            .output_on(output_on[g]),
            .overcurrent_timer_enable(overcurrent_timer_enable[g]),
            .tone_source_select(tone_source_select[g]),
            .tone_pass(tone_pass[g]),
            .cable_test_on(cable_test_on[g]),
            .regulator_on(regulator_on[g]),
            .test_source_on(test_source_on[g]),
            .boost_raise(boost_raise[g]),
            .cable_missing_flag(cable_missing_flag[g])
         );
      end
   endgenerate
   // ****************************************
   // write decode checks
   // ****************************************
   ch1_volt_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH1_VOLT
      |=> output_on[0] == $past(wr_data[5]))
      else $error("ch1 enable not written");
   ch2_volt_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH2_VOLT
      |=> output_on[1] == $past(wr_data[5]))
      else $error("ch2 enable not written");
   ch1_tone_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH1_TONE
      |=> tone_pass[0] == $past(wr_data[1])
          && tone_source_select[0] == $past(wr_data[0])
          && cable_test_on[0] == $past(wr_data[2]))
      else $error("ch1 tone not written");
   ch2_tone_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH2_TONE
      |=> tone_pass[1] == $past(wr_data[1])
          && tone_source_select[1] == $past(wr_data[0])
          && cable_test_on[1] == $past(wr_data[2]))
      else $error("ch2 tone not written");
   volt_only_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && !wr_data[7]
      |=> $stable(tone_pass) && $stable(tone_source_select)
          && $stable(cable_test_on))
      else $error("tone changed by voltage write");
   tone_only_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7] |=> $stable(output_on))
      else $error("enable changed by tone write");
   ch1_only_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH1_VOLT
      |=> $stable(output_on[1]))
      else $error("ch2 changed by ch1 write");
   ch2_only_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH2_VOLT
      |=> $stable(output_on[0]))
      else $error("ch1 changed by ch2 write");
   hold_a: assert property (
      @(posedge core_clk) disable iff (srst)
      !wr_strobe |=> $stable(output_on) && $stable(cable_test_on))
      else $error("control changed without write");
   // ****************************************
   // level, flag, timer and reset checks
   // ****************************************
   ch1_level_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH1_VOLT |=> ##1
      target_mv[15:0] == lnbctl_pkg::LEVEL_MV[$past(wr_data[3:0], 2)])
      else $error("ch1 level not programmed");
   ch2_level_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH2_VOLT |=> ##1
      target_mv[31:16] == lnbctl_pkg::LEVEL_MV[$past(wr_data[3:0], 2)])
      else $error("ch2 level not programmed");
   ch1_range_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH1_VOLT |=> ##1
      (target_mv[15:0] >= lnbctl_pkg::HIGH_BASE_MV) == $past(wr_data[3], 2))
      else $error("ch1 range not selected");
   ch2_range_a: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_strobe && wr_data[7:6] == lnbctl_pkg::SEL_CH2_VOLT |=> ##1
      (target_mv[31:16] >= lnbctl_pkg::HIGH_BASE_MV) == $past(wr_data[3], 2))
      else $error("ch2 range not selected");
   flag_off_a: assert property (
      @(posedge core_clk) disable iff (srst)
      (cable_missing_flag & ~$past(cable_test_on)) == 2'h0)
      else $error("cable flag set with test off");
   flag_hold_a: assert property (
      @(posedge core_clk) disable iff (srst)
      cable_test_on[0] && !above_s2[0] && !below_s2[0]
      |=> $stable(cable_missing_flag[0]))
      else $error("ch1 cable flag moved without cause");
   timer_a: assert property (
      @(posedge core_clk) disable iff (srst)
      overcurrent_timer_enable == 2'h3)
      else $error("timer disabled");
   reset_a: assert property (
      @(posedge core_clk)
      srst |=> output_on == 2'h0 && cable_test_on == 2'h0
          && tone_pass == 2'h0 && tone_source_select == 2'h0
          && cable_missing_flag == 2'h0)
      else $error("not zero after reset");
endmodule
`default_nettype wire

// [bench/lnbctl_wr_master.sv]
// lnbctl_wr_master: stands in for the serial engine feeding control bytes
// assumes the same core_clk as the bank, one byte per send call
`timescale 1ns/1ps
`default_nettype none
module lnbctl_wr_master (
   input wire logic core_clk,
   output logic wr_strobe,
   output logic [7:0] wr_data
);
   initial begin
      wr_strobe = 1'b0;
      wr_data = 8'h00;
   end
   // idle data is inverted so a stale byte never looks valid
   task automatic send(input logic [7:0] b);
      @(posedge core_clk);
      #1;
      wr_strobe = 1'b1;
      wr_data = b;
      @(posedge core_clk);
      #1;
      wr_strobe = 1'b0;
      wr_data = ~b;
   endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// tb_top: random writes and cable test against an integer model
// assumes lnbctl_pkg and the bank sources are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
fails++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   logic core_clk = 1'b0, srst = 1'b1, wr_strobe;
   logic [7:0] wr_data;
   logic [1:0] above = 2'h0, below = 2'h0;
   logic [31:0] target_mv;
   logic [1:0] on_o, ot_o, src_o, pass_o, test_o, reg_o, cur_o, bst_o, flg_o;
   int volt [2], tone [2], flag [2];
   int fails = 0, samples_checked = 0, seed = 85753;
   always #5 core_clk = ~core_clk;
   lnbctl_wr_master i_lnbctl_wr_master (.core_clk(core_clk),
      .wr_strobe(wr_strobe), .wr_data(wr_data));
   lnbctl_top i_lnbctl_top (.core_clk(core_clk), .srst(srst),
      .wr_strobe(wr_strobe), .wr_data(wr_data), .cmp_above_set_pin(above),
      .cmp_below_clr_pin(below), .target_mv(target_mv), .output_on(on_o),
      .overcurrent_timer_enable(ot_o), .tone_source_select(src_o),
      .tone_pass(pass_o), .cable_test_on(test_o), .regulator_on(reg_o),
      .test_source_on(cur_o), .boost_raise(bst_o),
      .cable_missing_flag(flg_o));
   // ****************************************
   // model and checks
   // ****************************************
   task automatic mreset();
      for (int c = 0; c < 2; c++) begin
         volt[c] = 0;
         tone[c] = 0;
         flag[c] = 0;
      end
   endtask
   task automatic wr(input logic [7:0] b);
      int s;
      s = b[7:6];
      if (s < 2) volt[s] = b[5:0];
      else tone[s - 2] = b[2:0];
      for (int c = 0; c < 2; c++) if (tone[c][2] == 0) flag[c] = 0;
      i_lnbctl_wr_master.send(b);
      repeat (4) @(posedge core_clk);
      #1;
   endtask
   task automatic check_all();
      int v, t, lvl, d, k;
      for (int c = 0; c < 2; c++) begin
         v = volt[c];
         t = tone[c];
         lvl = target_mv[16*c +: 16];
         k = v & 7;
         // a step is a third of a volt; listed levels use 333 or 334 mV steps, within 1 mV of that
         d = lvl - (v[3] ? lnbctl_pkg::HIGH_BASE_MV : lnbctl_pkg::LOW_BASE_MV)
            - (1000 * k) / 3;
         `CHK("level", lnbctl_pkg::LEVEL_MV[v[3:0]], target_mv[16*c +: 16])
         `CHK("step", 1'b1, (d >= -1 && d <= 1))
         `CHK("output_on", v[5], on_o[c])
         `CHK("oc_timer", 1'b1, ot_o[c])
         `CHK("tone_src", t[0], src_o[c])
         `CHK("tone_pass", t[1], pass_o[c])
         `CHK("cable_test", t[2], test_o[c])
         `CHK("regulator", v[5] & ~t[2], reg_o[c])
         `CHK("source", t[2], cur_o[c])
         `CHK("boost", t[2], bst_o[c])
         `CHK("cable_flag", flag[c][0], flg_o[c])
      end
   endtask
   task automatic pins(input int c, input logic a, input logic b, input int f);
      above[c] = a;
      below[c] = b;
      flag[c] = f;
      repeat (6) @(posedge core_clk);
      #1;
      check_all();
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      mreset();
      repeat (2) @(posedge core_clk);
      #1 srst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check_all();
      $display("test reset done");
      for (int i = 0; i < 60; i++) begin
         wr(8'($random(seed)));
         check_all();
      end
      $display("test random writes done");
      for (int c = 0; c < 2; c++) begin
         // master sets voltage and enable in one write, then test in the next
         wr({1'b0, c[0], 6'h2f});
         wr({1'b1, c[0], 6'h04});
         pins(c, 1'b1, 1'b0, 1);
         pins(c, 1'b0, 1'b0, 1);
         pins(c, 1'b0, 1'b1, 0);
         pins(c, 1'b1, 1'b0, 1);
         wr({1'b1, c[0], 6'h3b});
         check_all();
         pins(c, 1'b0, 1'b0, 0);
      end
      $display("test cable done");
      srst = 1'b1;
      mreset();
      @(posedge core_clk);
      #1 srst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check_all();
      $display("test second reset done");
      print_verdict();
   end
   initial begin
      #200us;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
